/* File: verilog/fast_converter_capture.sv */
// capture control logic of the fast converter with its sample fifo
`timescale 1ns/1ps

// ----------------------------------------------------------------
// sample fifo
// ----------------------------------------------------------------
module fast_converter_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;
    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_q];
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
            end
            if (push && !pop) begin
                count_q <= count_q + (AW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end
endmodule : fast_converter_fifo

// What this block does
// RL1 - one 8-bit sample per conversion, 12 Msps
// RL2 - peak/pit only below full 12 MHz rate
// RL3 - peak mode keeps largest sample per bucket
// RL4 - pit mode keeps smallest sample per bucket
// RL5 - sample mode keeps final bucket sample
// RL6 - latch loads when latch_hold low, else holds
// RL7 - full_rate_select forces latch_hold low
// RL8 - comparator flags new above or below held
// RL9 - sample mode keeps latch_hold low
// RL10 - peak/pit loads on first sample or improvement
// RL11 - ram stores latch only in write mode
// RL12 - host link: byte bus, address, two strobes
// RL13 - address low primary, high secondary
// RL14 - word as high byte then low byte
// RL15 - primary holds the 16-bit control word
// RL16 - secondary takes byte and word accesses
// RL17 - host sets direction before secondary access
// RL18 - bit 0 runs capture, blocks host reads
// RL19 - bit 1 arms trigger acceptance
// RL20 - bit 2 drives log expand gain
// RL21 - bit 3 picks video trigger edge
// RL22 - bit 4 sample mode, bit 5 store enable
// RL23 - bit 15 picks pit over peak
// RL24 - bucket_first_sample comes from rate generator
module fast_converter_capture
    import fast_converter_pkg::*;
#(
    parameter int RAM_ADDR_W = RAM_AW,
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] conv_sample,
    input wire logic full_rate_select,
    input wire logic bucket_first_sample,
    input wire logic sweep_trigger_line,
    input wire logic video_trigger_line,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    input wire logic addr_select_line,
    input wire logic high_byte_strobe,
    input wire logic low_byte_strobe,
    output logic latch_hold,
    output logic new_below_held,
    output logic new_above_held,
    output logic [7:0] latch_out,
    output logic log_expand_gain,
    output logic video_trigger_polarity,
    output logic capture_armed,
    output logic trigger_fired,
    output logic clocks_running
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [7:0] smp_s1_q;
    logic [7:0] smp_s2_q;
    logic [7:0] hd_s1_q;
    logic [7:0] hd_s2_q;
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic [4:0] pin_s3_q;
    logic addr_sel;
    logic hi_stb;
    logic lo_stb;
    logic hi_rise;
    logic lo_rise;
    logic hi_fall;
    logic lo_fall;
    logic sweep_rise;
    logic video_rise;
    logic video_fall;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            smp_s1_q <= 8'h00;
            smp_s2_q <= 8'h00;
            hd_s1_q <= 8'h00;
            hd_s2_q <= 8'h00;
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            pin_s3_q <= 5'h00;
        end else begin
            smp_s1_q <= conv_sample;
            smp_s2_q <= smp_s1_q;
            hd_s1_q <= host_data_in;
            hd_s2_q <= hd_s1_q;
            pin_s1_q <= {video_trigger_line, sweep_trigger_line, low_byte_strobe, high_byte_strobe,
                         addr_select_line};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    assign addr_sel = pin_s2_q[0];
    assign hi_stb = pin_s2_q[1];
    assign lo_stb = pin_s2_q[2];
    assign hi_rise = pin_s2_q[1] & ~pin_s3_q[1];
    assign lo_rise = pin_s2_q[2] & ~pin_s3_q[2];
    assign hi_fall = ~pin_s2_q[1] & pin_s3_q[1];
    assign lo_fall = ~pin_s2_q[2] & pin_s3_q[2];
    assign sweep_rise = pin_s2_q[3] & ~pin_s3_q[3];
    assign video_rise = pin_s2_q[4] & ~pin_s3_q[4];
    assign video_fall = ~pin_s2_q[4] & pin_s3_q[4];

    // ----------------------------------------------------------------
    // control word at the primary location
    // ----------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic write_mode;
    logic store_en;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RESET;
        end else if (addr_sel == LOC_PRIMARY) begin // RL13
            if (hi_rise) begin
                ctrl_q[15:8] <= hd_s2_q; // RL14 RL15
            end
            if (lo_rise) begin
                ctrl_q[7:0] <= hd_s2_q; // RL14 RL15
            end
        end
    end
    assign write_mode = ctrl_q[CW_WRITE_MODE]; // RL18
    assign store_en = write_mode & ~ctrl_q[CW_STORE_ENABLE_N]; // RL22
    assign clocks_running = write_mode; // RL18
    assign capture_armed = ctrl_q[CW_ARM]; // RL19
    assign log_expand_gain = ctrl_q[CW_LOG_EXPAND_GAIN]; // RL20
    assign video_trigger_polarity = ctrl_q[CW_VIDEO_TRIG_POL]; // RL21

    // ----------------------------------------------------------------
    // trigger acceptance
    // ----------------------------------------------------------------
    logic video_edge;
    assign video_edge = video_trigger_polarity ? video_fall : video_rise; // RL21
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trigger_fired <= 1'b0;
        end else begin
            trigger_fired <= write_mode & capture_armed & (sweep_rise | video_edge); // RL19
        end
    end

    // ----------------------------------------------------------------
    // conversion timing, 12 of every 100 core cycles
    // ----------------------------------------------------------------
    logic [6:0] conv_acc_q;
    logic conv_tick;
    logic [6:0] acc_sum;
    assign acc_sum = conv_acc_q + CONV_ACC_STEP;
    assign conv_tick = write_mode & (acc_sum >= CONV_ACC_WRAP); // RL1 RL18
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            conv_acc_q <= 7'h00;
        end else if (write_mode) begin
            conv_acc_q <= conv_tick ? acc_sum - CONV_ACC_WRAP : acc_sum; // RL1
        end else begin
            conv_acc_q <= 7'h00;
        end
    end

    // ----------------------------------------------------------------
    // detector: comparator and latch control
    // ----------------------------------------------------------------
    fast_converter_det_t det_mode;
    logic [7:0] new_smp;
    logic [7:0] latch_q;
    logic buf_ready;
    logic load;
    function automatic logic [1:0] fast_converter_compare(input logic [7:0] p, input logic [7:0] q);
        fast_converter_compare = {p < q, p > q}; // RL8
    endfunction : fast_converter_compare
    assign new_smp = smp_s2_q; // RL1
    assign {new_below_held, new_above_held} = fast_converter_compare(new_smp, latch_q); // RL8
    always_comb begin
        if (full_rate_select) begin
            det_mode = FAST_CONVERTER_DET_FULL; // RL2
        end else if (!ctrl_q[CW_SAMPLE_MODE_N]) begin
            det_mode = FAST_CONVERTER_DET_SAMPLE; // RL22
        end else if (ctrl_q[CW_PIT_SELECT]) begin
            det_mode = FAST_CONVERTER_DET_PIT; // RL23
        end else begin
            det_mode = FAST_CONVERTER_DET_PEAK; // RL23
        end
    end
    always_comb begin
        case (det_mode)
            FAST_CONVERTER_DET_FULL: latch_hold = 1'b0; // RL7
            FAST_CONVERTER_DET_SAMPLE: latch_hold = 1'b0; // RL9 RL5
            FAST_CONVERTER_DET_PEAK: latch_hold = ~(bucket_first_sample | new_above_held); // RL10 RL3 RL24
            FAST_CONVERTER_DET_PIT: latch_hold = ~(bucket_first_sample | new_below_held); // RL10 RL4 RL24
            default: latch_hold = 1'b0;
        endcase
    end
    // a full buffer stalls the latch so no stored value is overwritten
    assign load = conv_tick & ~latch_hold & buf_ready; // RL6
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            latch_q <= LATCH_RESET;
        end else if (load) begin
            latch_q <= new_smp; // RL6
        end
    end
    assign latch_out = latch_q;

    // ----------------------------------------------------------------
    // store requests toward the ram
    // ----------------------------------------------------------------
    logic bucket_open_q;
    logic full_push_q;
    logic push_req;
    logic [7:0] push_data;
    // below full rate a bucket is finished when the next one begins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bucket_open_q <= 1'b0;
        end else if (!write_mode) begin
            bucket_open_q <= 1'b0;
        end else if (conv_tick && bucket_first_sample && buf_ready) begin
            bucket_open_q <= 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            full_push_q <= 1'b0;
        end else begin
            full_push_q <= load & full_rate_select; // RL7
        end
    end
    assign push_req = full_push_q |
                      (conv_tick & bucket_first_sample & bucket_open_q & ~full_rate_select);
    assign push_data = latch_q; // RL11

    // ----------------------------------------------------------------
    // buffer between latch and ram
    // ----------------------------------------------------------------
    logic [7:0] buf_data;
    logic buf_valid;
    logic ram_take;
    fast_converter_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(BUF_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_data(push_data),
        .in_valid(push_req),
        .in_ready(buf_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(ram_take)
    );

    // ----------------------------------------------------------------
    // sample ram and its address counter
    // ----------------------------------------------------------------
    logic [7:0] ram [2**RAM_ADDR_W];
    logic [RAM_ADDR_W-1:0] addr_q;
    logic sec_access;
    logic host_read;
    assign ram_take = store_en; // RL11
    assign sec_access = (addr_sel == LOC_SECONDARY); // RL13
    assign host_read = ~write_mode & sec_access; // RL18 RL17
    always_ff @(posedge core_clk) begin
        if (buf_valid && ram_take) begin
            ram[addr_q] <= buf_data; // RL11
        end
    end
    // circular counter: advances on each stored sample, is loaded by host writes at the
    // secondary location in write mode and post-increments after each host read byte
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= '0;
        end else if (buf_valid && ram_take) begin
            addr_q <= addr_q + RAM_ADDR_W'(1);
        end else if (write_mode && sec_access && hi_rise) begin
            addr_q <= {hd_s2_q[RAM_ADDR_W-9:0], addr_q[7:0]}; // RL16 RL14
        end else if (write_mode && sec_access && lo_rise) begin
            addr_q <= {addr_q[RAM_ADDR_W-1:8], hd_s2_q}; // RL16 RL14
        end else if (host_read && (hi_fall || lo_fall)) begin
            addr_q <= addr_q + RAM_ADDR_W'(1); // RL16
        end
    end

    // ----------------------------------------------------------------
    // host read driver
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            host_data_out <= 8'h00;
        end else if (host_read) begin
            host_data_out <= ram[addr_q]; // RL11 RL12
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            host_data_oe <= 1'b0;
        end else begin
            host_data_oe <= host_read & (hi_stb | lo_stb); // RL12 RL18
        end
    end
endmodule : fast_converter_capture

/* File: shared/fast_converter_pkg.sv */
// constants shared by the fast converter capture control block
package fast_converter_pkg;
    // ----------------------------------------------------------------
    // clocking and conversion timing
    // ----------------------------------------------------------------
    localparam int CORE_CLK_MHZ = 100;
    localparam int CONV_RATE_MHZ = 12;
    localparam int PEAK_SWEEP_MIN_US = 50;
    localparam int PEAK_SWEEP_MIN_CYC = PEAK_SWEEP_MIN_US * CORE_CLK_MHZ;
    localparam logic [6:0] CONV_ACC_STEP = 7'(CONV_RATE_MHZ);
    localparam logic [6:0] CONV_ACC_WRAP = 7'(CORE_CLK_MHZ);

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int SAMPLE_W = 8;
    localparam int CTRL_W = 16;
    localparam int RAM_AW = 15;
    localparam int FIFO_DEPTH = 16;

    // ----------------------------------------------------------------
    // host locations, selected by addr_select_line
    // ----------------------------------------------------------------
    localparam logic LOC_PRIMARY = 1'b0;
    localparam logic LOC_SECONDARY = 1'b1;

    // ----------------------------------------------------------------
    // capture_control_word field positions
    // ----------------------------------------------------------------
    localparam int CW_WRITE_MODE = 0;
    localparam int CW_ARM = 1;
    localparam int CW_LOG_EXPAND_GAIN = 2;
    localparam int CW_VIDEO_TRIG_POL = 3;
    localparam int CW_SAMPLE_MODE_N = 4;
    localparam int CW_STORE_ENABLE_N = 5;
    localparam int CW_PIT_SELECT = 15;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET = 16'h0030;
    localparam logic [7:0] LATCH_RESET = 8'h00;

    // ----------------------------------------------------------------
    // detector selection
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FAST_CONVERTER_DET_SAMPLE,
        FAST_CONVERTER_DET_PEAK,
        FAST_CONVERTER_DET_PIT,
        FAST_CONVERTER_DET_FULL
    } fast_converter_det_t;
endpackage : fast_converter_pkg

/* File: verification/fast_converter_capture_monitor.sv */
// port checker of the capture control block
`timescale 1ns/1ps
module fast_converter_capture_monitor
    import fast_converter_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] conv_sample,
    input wire logic full_rate_select,
    input wire logic bucket_first_sample,
    input wire logic latch_hold,
    input wire logic new_below_held,
    input wire logic new_above_held,
    input wire logic [7:0] latch_out,
    input wire logic clocks_running,
    input wire logic capture_armed,
    input wire logic trigger_fired,
    input wire logic host_data_oe
);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    // counts the first edges after reset, while the input synchroniser still holds reset values
    logic [1:0] age_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    sequence pulse_s;
        trigger_fired ##1 !trigger_fired;
    endsequence
    sequence unarmed_s;
        !capture_armed ##1 !capture_armed;
    endsequence
    full_forces_load_a: assert property (full_rate_select |-> !latch_hold)
        else $error("latch hold high at full rate");
    first_loads_a: assert property (bucket_first_sample |-> !latch_hold)
        else $error("latch hold high on first bucket sample");
    hold_keeps_a: assert property (latch_hold |=> $stable(latch_out))
        else $error("latch changed while held");
    stopped_keeps_a: assert property (!clocks_running [*3] |=> $stable(latch_out))
        else $error("latch changed with clocks stopped");
    cmp_exclusive_a: assert property (!(new_below_held && new_above_held))
        else $error("comparator flags both high");
    above_flag_a: assert property (age_q == 2'h3 |-> new_above_held == ($past(conv_sample, 2) > latch_out))
        else $error("above flag disagrees with sample and latch");
    below_flag_a: assert property (age_q == 2'h3 |-> new_below_held == ($past(conv_sample, 2) < latch_out))
        else $error("below flag disagrees with sample and latch");
    write_blocks_read_a: assert property (clocks_running |-> !host_data_oe)
        else $error("bus driven in write mode");
    unarmed_silent_a: assert property (unarmed_s |-> !trigger_fired)
        else $error("trigger fired while unarmed");
    fire_pulse_a: assert property (trigger_fired |-> pulse_s)
        else $error("trigger pulse longer than one cycle");
endmodule : fast_converter_capture_monitor

bind fast_converter_capture fast_converter_capture_monitor u_mon (.core_clk(core_clk), .nrst(nrst), .conv_sample(conv_sample),
    .full_rate_select(full_rate_select), .bucket_first_sample(bucket_first_sample),
    .latch_hold(latch_hold), .new_below_held(new_below_held), .new_above_held(new_above_held),
    .latch_out(latch_out), .clocks_running(clocks_running), .capture_armed(capture_armed),
    .trigger_fired(trigger_fired), .host_data_oe(host_data_oe));

/* File: verification/fast_converter_host_model.sv */
// host processor model on the strobed byte bus
`timescale 1ns/1ps
module fast_converter_host_model (
    input wire logic core_clk,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe,
    output logic [7:0] host_data_in,
    output logic addr_select_line,
    output logic high_byte_strobe,
    output logic low_byte_strobe
);
    logic drive_en = 1'b0;
    logic [7:0] drive_val = 8'h00;
    logic [7:0] last_val = 8'h00;
    // resolved bus; a released bus shows a changing pattern
    assign host_data_in = host_data_oe ? host_data_out : (drive_en ? drive_val : ~last_val);
    always @(posedge core_clk) last_val <= host_data_in;
    initial begin
        addr_select_line = 1'b0;
        high_byte_strobe = 1'b0;
        low_byte_strobe = 1'b0;
    end
    // one byte transfer, data and address held across the strobe
    task automatic strobe(input logic hi, input logic loc, input logic en, input logic [7:0] val);
        @(posedge core_clk);
        #1;
        addr_select_line = loc;
        drive_en = en;
        drive_val = val;
        high_byte_strobe = hi;
        low_byte_strobe = !hi;
        repeat (5) @(posedge core_clk);
        #1;
        high_byte_strobe = 1'b0;
        low_byte_strobe = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        drive_en = 1'b0;
    endtask : strobe
    task automatic wr_word(input logic loc, input logic [15:0] w);
        strobe(1'b1, loc, 1'b1, w[15:8]);
        strobe(1'b0, loc, 1'b1, w[7:0]);
    endtask : wr_word
    task automatic rd_byte(input logic loc);
        strobe(1'b0, loc, 1'b0, 8'h00);
    endtask : rd_byte
endmodule : fast_converter_host_model

/* File: verification/tb_top.sv */
// self-checking bench of the capture control block
`timescale 1ns/1ps
module tb_top;
    import fast_converter_pkg::*;
    typedef struct {int id; logic [7:0] exp; string name;} fast_converter_note_t;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] conv_sample = 8'h00;
    logic full_rate_select = 1'b0;
    logic bucket_first_sample = 1'b0;
    logic sweep_trigger_line = 1'b0;
    logic video_trigger_line = 1'b0;
    logic [7:0] host_data_in, host_data_out, latch_out;
    logic host_data_oe, addr_select_line, high_byte_strobe, low_byte_strobe;
    logic latch_hold, new_below_held, new_above_held, log_expand_gain;
    logic video_trigger_polarity, capture_armed, trigger_fired, clocks_running;
    logic oe_q = 1'b0;
    logic oe_qq = 1'b0;
    int n_errors = 0;
    int checked = 0;
    int seed = 40432;
    int fire_cnt = 0;
    fast_converter_note_t exp_q[$];
    event snap_ev;
    always #5 core_clk = ~core_clk;
    fast_converter_capture u_dut (.core_clk(core_clk), .nrst(nrst), .conv_sample(conv_sample),
        .full_rate_select(full_rate_select), .bucket_first_sample(bucket_first_sample),
        .sweep_trigger_line(sweep_trigger_line), .video_trigger_line(video_trigger_line),
        .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .addr_select_line(addr_select_line), .high_byte_strobe(high_byte_strobe),
        .low_byte_strobe(low_byte_strobe), .latch_hold(latch_hold), .new_below_held(new_below_held),
        .new_above_held(new_above_held), .latch_out(latch_out), .log_expand_gain(log_expand_gain),
        .video_trigger_polarity(video_trigger_polarity), .capture_armed(capture_armed),
        .trigger_fired(trigger_fired), .clocks_running(clocks_running));
    fast_converter_host_model u_host (.core_clk(core_clk), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .host_data_in(host_data_in), .addr_select_line(addr_select_line),
        .high_byte_strobe(high_byte_strobe), .low_byte_strobe(low_byte_strobe));
    // ----------------------------------------------------------------
    // checking
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic take(input logic [7:0] seen);
        fast_converter_note_t n;
        n = exp_q.pop_front();
        check(n.name, n.exp, seen);
    endtask : take
    task automatic note_now(input int id, input logic [7:0] exp, input string name);
        exp_q.push_back('{id, exp, name});
        -> snap_ev;
        #1;
    endtask : note_now
    always @(snap_ev) begin
        case (exp_q[0].id)
            1: take(latch_out);
            2: take({4'h0, video_trigger_polarity, log_expand_gain, capture_armed, clocks_running});
            3: take({6'h00, new_below_held, new_above_held});
            default: take(8'(fire_cnt));
        endcase
    end
    always @(posedge core_clk) begin
        oe_q <= host_data_oe;
        oe_qq <= oe_q;
        if (oe_q && !oe_qq) take(host_data_out);
        if (trigger_fired === 1'b1) fire_cnt <= fire_cnt + 1;
    end
    task automatic test_done();
        if (exp_q.size() != 0) n_errors++;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    task automatic do_reset();
        nrst = 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : do_reset
    task automatic bucket(input logic [15:0] ctrl, input int kind);
        logic [7:0] v [3];
        logic [7:0] want;
        u_host.wr_word(LOC_PRIMARY, ctrl);
        for (int i = 0; i < 3; i++) begin
            v[i] = 8'($random(seed));
            conv_sample = v[i];
            bucket_first_sample = (i == 0);
            repeat (30) @(posedge core_clk);
            #1;
        end
        want = v[0];
        for (int i = 1; i < 3; i++) begin
            if (kind == 1 && v[i] > want) want = v[i];
            if (kind == 2 && v[i] < want) want = v[i];
        end
        if (kind == 0) want = v[2];
        note_now(1, want, "latch_out");
        note_now(3, {6'h00, v[2] < want, v[2] > want}, "compare");
    endtask : bucket
    task automatic pulse_line(input logic vid);
        sweep_trigger_line = !vid;
        video_trigger_line = vid;
        repeat (6) @(posedge core_clk);
        #1;
        sweep_trigger_line = 1'b0;
        video_trigger_line = 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
    endtask : pulse_line
    initial begin
        logic [7:0] v;
        int c0;
        do_reset();
        note_now(2, 8'h00, "control_out");
        note_now(1, LATCH_RESET, "latch_out");
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            u_host.wr_word(LOC_PRIMARY, {12'h003, v[3:0]});
            note_now(2, {4'h0, v[3:0]}, "control_out");
        end
        bucket(16'h0021, 0);
        bucket(16'h0031, 1);
        bucket(16'h8031, 2);
        c0 = fire_cnt;
        pulse_line(1'b0);
        u_host.wr_word(LOC_PRIMARY, 16'h0033);
        pulse_line(1'b0);
        pulse_line(1'b1);
        u_host.wr_word(LOC_PRIMARY, 16'h003b);
        pulse_line(1'b1);
        note_now(4, 8'(c0 + 3), "trigger_count");
        do_reset();
        v = 8'($random(seed));
        conv_sample = v;
        full_rate_select = 1'b1;
        u_host.wr_word(LOC_PRIMARY, 16'h0021);
        repeat (300) @(posedge core_clk);
        u_host.wr_word(LOC_SECONDARY, 16'h0000);
        u_host.wr_word(LOC_PRIMARY, 16'h0001);
        repeat (150) @(posedge core_clk);
        u_host.wr_word(LOC_PRIMARY, 16'h0021);
        u_host.wr_word(LOC_SECONDARY, 16'h0000);
        u_host.wr_word(LOC_PRIMARY, 16'h0030);
        full_rate_select = 1'b0;
        for (int i = 0; i < 4; i++) begin
            exp_q.push_back('{0, v, "ram_data"});
            u_host.rd_byte(LOC_SECONDARY);
        end
        repeat (10) @(posedge core_clk);
        test_done();
    end
    initial begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        test_done();
    end
endmodule : tb_top
